// *** rtl/isr_cfg.svh ***
// constants for the two-wire slave receive path: offsets, bit positions, reset values
// Overview of operation
// RULE1 - ack check off: ignore returned ack, continue
// RULE2 - ack check on and ack 1: halt transfer
// RULE3 - drive ack_send_value in the acknowledge slot
// RULE4 - own address held in bits 7:1
// RULE5 - bit 0 selects addressed or clocked format
// RULE6 - first frame matching address sets match flag
// RULE7 - match flag cleared by 0 after read 1
// RULE8 - byte moved to holding register sets full
// RULE9 - full cleared by data read or 0-after-1
// RULE10 - 8-bit holding register loaded per byte
// RULE11 - holding register read-only, resets to all ones
// RULE12 - frame has ack; count field returns 000
// RULE13 - software keeps MSB-first in addressed format
// RULE14 - address compared before the acknowledge slot
`ifndef ISR_CFG_SVH
`define ISR_CFG_SVH

// ****************************************
// register indices, byte address is index times four
// ****************************************
`define ISR_IDX_MODE 16'hf078
`define ISR_IDX_ACK 16'hf07b
`define ISR_IDX_FLAG 16'hf07c
`define ISR_IDX_SAR 16'hf07d
`define ISR_IDX_RX 16'hf07f
`define ISR_IDX_IST 16'hf080
`define ISR_IDX_IMK 16'hf081

// ****************************************
// field positions
// ****************************************
`define ISR_ACK_CHK_BIT 2
`define ISR_ACK_SND_BIT 0
`define ISR_RXFULL_BIT 5
`define ISR_AMATCH_BIT 1
`define ISR_ORDER_BIT 7
`define ISR_EV_MATCH 0
`define ISR_EV_BYTE 1
`define ISR_EV_STOP 2
`define ISR_EV_NACK 3

// ****************************************
// reset values and counts
// ****************************************
`define ISR_RX_RST 8'hff
`define ISR_REG_RST 8'h00
`define ISR_ADDR_BITS 4'h7
`define ISR_FULL_LEN 4'h8

`endif

// *** rtl/isr_pkg.sv ***
// types shared by the two-wire slave receive path
package isr_pkg;
    typedef logic [31:0] isr_word_t;
    typedef enum logic [2:0]
    {
        ISR_IDLE = 3'h0,
        ISR_ADDR = 3'h1,
        ISR_DATA = 3'h2,
        ISR_ACK = 3'h3,
        ISR_SYNC = 3'h4
    } isr_state_t;
    typedef struct packed
    {
        logic chk;
        logic snd;
    } isr_ack_ctl_t;
    typedef struct packed
    {
        logic [6:0] addr;
        logic fmt;
    } isr_sar_t;
    typedef struct packed
    {
        logic order;
        logic [2:0] bc;
    } isr_mode_t;
endpackage : isr_pkg

// *** rtl/isr_sync.sv ***
// two flip-flop synchroniser for pin levels
`timescale 1ns/10ps
module isr_sync
#(
    parameter int W = 1
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    import isr_pkg::*;
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // idle bus reads high, so reset to ones
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_ff <= '1;
            sync_ff <= '1;
        end
        else if (ce_i)
        begin
            meta_ff <= d_i;
            sync_ff <= meta_ff;
        end
    end

    assign q_o = sync_ff;
endmodule : isr_sync

// *** rtl/isr_top.sv ***
// slave receive path of the two-wire serial interface, wishbone register slave
`timescale 1ns/10ps
`include "isr_cfg.svh"
module isr_top
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [17:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire isr_pkg::isr_word_t dat_i,
    output isr_pkg::isr_word_t dat_o,
    output logic ack_o,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic irq_o
);
    import isr_pkg::*;

    // ****************************************
    // pin synchronisers and bus conditions
    // ****************************************
    logic scl_s;
    logic sda_s;
    logic scl_q_ff;
    logic sda_q_ff;
    logic scl_rise;
    logic scl_fall;
    logic start_w;
    logic stop_w;

    isr_sync #(.W(1)) u_scl (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .d_i(scl_i), .q_o(scl_s));
    isr_sync #(.W(1)) u_sda (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .d_i(sda_i), .q_o(sda_s));

    // one extra stage for edge detection, fed only by synchronised levels
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
        end
        else if (ce_i)
        begin
            scl_q_ff <= scl_s;
            sda_q_ff <= sda_s;
        end
    end

    // data edges while clock is high mark start and stop
    assign scl_rise = scl_s & ~scl_q_ff;
    assign scl_fall = ~scl_s & scl_q_ff;
    assign start_w = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
    assign stop_w = scl_s & scl_q_ff & ~sda_q_ff & sda_s;

    // ****************************************
    // wishbone decode
    // ****************************************
    logic ack_ff;
    logic acc_w;
    logic rd_w;
    logic wr_w;
    logic [15:0] idx_w;
    logic hit_mode;
    logic hit_ack;
    logic hit_flag;
    logic hit_sar;
    logic hit_rx;
    logic hit_ist;
    logic hit_imk;

    // one access per strobe; the ack cycle itself is not a new access
    assign acc_w = cyc_i & stb_i & ~ack_ff & ce_i;
    assign rd_w = acc_w & ~we_i;
    assign wr_w = acc_w & we_i & sel_i[0];
    assign idx_w = adr_i[17:2];
    assign hit_mode = idx_w == `ISR_IDX_MODE;
    assign hit_ack = idx_w == `ISR_IDX_ACK;
    assign hit_flag = idx_w == `ISR_IDX_FLAG;
    assign hit_sar = idx_w == `ISR_IDX_SAR;
    assign hit_rx = idx_w == `ISR_IDX_RX;
    assign hit_ist = idx_w == `ISR_IDX_IST;
    assign hit_imk = idx_w == `ISR_IDX_IMK;

    // ****************************************
    // registers and flags
    // ****************************************
    isr_ack_ctl_t ack_ctl_ff;
    isr_sar_t sar_ff;
    isr_mode_t mode_ff;
    logic [7:0] rx_data_ff;
    logic aas_ff;
    logic aas_arm_ff;
    logic rx_full_flag_ff;
    logic rx_full_flag_arm_ff;
    logic [3:0] ist_ff;
    logic [3:0] imk_ff;
    logic [31:0] dat_ff;
    logic [7:0] rdat8;
    logic clr_aas;
    logic clr_rx_full_flag;
    logic nxt_aas;
    logic nxt_rx_full_flag;
    logic nxt_aas_arm;
    logic nxt_rx_full_flag_arm;
    logic [3:0] nxt_ist;
    logic [3:0] ev_w;

    // ****************************************
    // receive state machine
    // ****************************************
    isr_state_t st_ff;
    isr_state_t nxt_st;
    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;
    logic [7:0] shift_ff;
    logic [7:0] nxt_shift;
    logic [7:0] shift_w;
    logic [3:0] dlen_w;
    logic sda_oe_ff;
    logic nxt_oe;
    logic ev_match;
    logic ev_byte;
    logic ev_nack;
    logic ev_ackend;
    logic ev_stop;

    // clocked format may be lsb first; addressed format expects msb first
    assign shift_w = mode_ff.order ? {sda_s, shift_ff[7:1]} : {shift_ff[6:0], sda_s};
    assign dlen_w = (mode_ff.bc == 3'h0) ? `ISR_FULL_LEN : {1'b0, mode_ff.bc} + 4'h1;

    // frame sequencing; in addressed format start and stop override any phase, in clocked format they are ignored
    always_comb
    begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_shift = shift_ff;
        nxt_oe = sda_oe_ff;
        ev_match = 1'b0;
        ev_byte = 1'b0;
        ev_nack = 1'b0;
        ev_ackend = 1'b0;
        ev_stop = 1'b0;
        if (sar_ff.fmt) // RULE5
        begin
            nxt_oe = 1'b0;
            if (st_ff != ISR_SYNC)
            begin
                nxt_st = ISR_SYNC;
                nxt_cnt = 4'h0;
            end
            else if (scl_rise)
            begin
                nxt_shift = shift_w;
                nxt_cnt = cnt_ff + 4'h1;
                if (cnt_ff == dlen_w - 4'h1)
                begin
                    ev_byte = 1'b1;
                    nxt_cnt = 4'h0;
                end
            end
        end
        else if (start_w)
        begin
            nxt_st = ISR_ADDR;
            nxt_cnt = 4'h0;
            nxt_oe = 1'b0;
        end
        else if (stop_w)
        begin
            ev_stop = st_ff != ISR_IDLE;
            nxt_st = ISR_IDLE;
            nxt_oe = 1'b0;
        end
        else
        begin
            case (st_ff)
                ISR_ADDR:
                begin
                    if (scl_rise)
                    begin
                        nxt_shift = {shift_ff[6:0], sda_s};
                        nxt_cnt = cnt_ff + 4'h1;
                        // decided on the eighth rise, before the ack slot
                        if (cnt_ff == `ISR_ADDR_BITS) // RULE14
                        begin
                            nxt_cnt = 4'h0;
                            if (nxt_shift[7:1] == sar_ff.addr && !nxt_shift[0]) // RULE4
                            begin
                                ev_match = 1'b1; // RULE6
                                nxt_st = ISR_ACK;
                            end
                            else
                            begin
                                nxt_st = ISR_IDLE;
                            end
                        end
                    end
                end
                ISR_DATA:
                begin
                    if (scl_rise)
                    begin
                        nxt_shift = shift_w;
                        nxt_cnt = cnt_ff + 4'h1;
                        if (cnt_ff == dlen_w - 4'h1)
                        begin
                            ev_byte = 1'b1; // RULE10
                            nxt_cnt = 4'h0;
                            nxt_st = ISR_ACK; // RULE12
                        end
                    end
                end
                ISR_ACK:
                begin
                    // phase 0 drive, phase 1 judge, phase 2 release
                    if (scl_fall && cnt_ff == 4'h0)
                    begin
                        nxt_oe = ~ack_ctl_ff.snd; // RULE3
                        nxt_cnt = 4'h1;
                    end
                    else if (scl_rise && cnt_ff == 4'h1)
                    begin
                        nxt_cnt = 4'h2;
                        if (ack_ctl_ff.chk && sda_s) // RULE2
                        begin
                            ev_nack = 1'b1;
                            nxt_oe = 1'b0;
                            nxt_st = ISR_IDLE;
                        end
                    end
                    else if (scl_fall && cnt_ff == 4'h2)
                    begin
                        nxt_oe = 1'b0; // RULE1
                        nxt_cnt = 4'h0;
                        ev_ackend = 1'b1;
                        nxt_st = ISR_DATA;
                    end
                end
                default:
                begin
                    nxt_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_ff <= ISR_IDLE;
            cnt_ff <= 4'h0;
            shift_ff <= `ISR_REG_RST;
            sda_oe_ff <= 1'b0;
        end
        else if (ce_i)
        begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            shift_ff <= nxt_shift;
            sda_oe_ff <= nxt_oe;
        end
    end

    // ****************************************
    // flag logic, hardware set wins over software clear
    // ****************************************
    assign clr_aas = wr_w & hit_flag & ~dat_i[`ISR_AMATCH_BIT] & aas_arm_ff; // RULE7
    assign clr_rx_full_flag = (wr_w & hit_flag & ~dat_i[`ISR_RXFULL_BIT] & rx_full_flag_arm_ff)
        | (rd_w & hit_rx); // RULE9
    assign nxt_aas = ev_match | (aas_ff & ~clr_aas);
    assign nxt_rx_full_flag = ev_byte | (rx_full_flag_ff & ~clr_rx_full_flag); // RULE8
    // arming remembers a read that saw the flag high
    assign nxt_aas_arm = (rd_w & hit_flag & aas_ff) | (aas_arm_ff & aas_ff & ~clr_aas);
    assign nxt_rx_full_flag_arm = (rd_w & hit_flag & rx_full_flag_ff) | (rx_full_flag_arm_ff & rx_full_flag_ff & ~clr_rx_full_flag);
    assign ev_w = {ev_nack, ev_stop, ev_byte, ev_match};
    assign nxt_ist = (ist_ff & ~((wr_w & hit_ist) ? dat_i[3:0] : 4'h0)) | ev_w;

    // read data selection, reserved bits read zero
    assign rdat8 = hit_ack ? {5'h00, ack_ctl_ff.chk, 1'b0, ack_ctl_ff.snd}
        : hit_flag ? {2'h0, rx_full_flag_ff, 3'h0, aas_ff, 1'b0}
        : hit_sar ? sar_ff
        : hit_rx ? rx_data_ff
        : hit_mode ? {mode_ff.order, 4'h0, mode_ff.bc}
        : hit_ist ? {4'h0, ist_ff}
        : hit_imk ? {4'h0, imk_ff}
        : 8'h00;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_ctl_ff <= '0;
            sar_ff <= `ISR_REG_RST;
            mode_ff <= '0;
            rx_data_ff <= `ISR_RX_RST; // RULE11
            aas_ff <= 1'b0;
            aas_arm_ff <= 1'b0;
            rx_full_flag_ff <= 1'b0;
            rx_full_flag_arm_ff <= 1'b0;
            ist_ff <= 4'h0;
            imk_ff <= 4'h0;
            ack_ff <= 1'b0;
            dat_ff <= 32'h0000_0000;
        end
        else if (ce_i)
        begin
            ack_ff <= acc_w;
            aas_ff <= nxt_aas;
            aas_arm_ff <= nxt_aas_arm;
            rx_full_flag_ff <= nxt_rx_full_flag;
            rx_full_flag_arm_ff <= nxt_rx_full_flag_arm;
            ist_ff <= nxt_ist;
            if (rd_w)
                dat_ff <= {24'h00_0000, rdat8};
            if (wr_w && hit_ack)
                ack_ctl_ff <= {dat_i[`ISR_ACK_CHK_BIT], dat_i[`ISR_ACK_SND_BIT]};
            if (wr_w && hit_sar)
                sar_ff <= dat_i[7:0];
            if (wr_w && hit_imk)
                imk_ff <= dat_i[3:0];
            // the count field falls back to 000 once each ack completes
            if (ev_ackend)
                mode_ff.bc <= 3'h0; // RULE12
            else if (wr_w && hit_mode)
                mode_ff.bc <= dat_i[2:0];
            if (wr_w && hit_mode)
                mode_ff.order <= dat_i[`ISR_ORDER_BIT]; // RULE13
            // cpu writes never reach the holding register
            if (ev_byte)
                rx_data_ff <= nxt_shift; // RULE10
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // open drain: only ever pulls low, release lets the bus float high
    assign sda_o = 1'b0;
    assign sda_oe_o = sda_oe_ff;
    assign ack_o = ack_ff;
    assign dat_o = dat_ff;
    assign irq_o = |(ist_ff & imk_ff);

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_rx_ro;
        wr_w && hit_rx && !ev_byte |=> $stable(rx_data_ff);
    endproperty
    a_rx_ro: assert property (p_rx_ro) else $error("holding reg changed by write"); // RULE11

    property p_full_set;
        ce_i && ev_byte |=> rx_full_flag_ff && ist_ff[`ISR_EV_BYTE];
    endproperty
    a_full_set: assert property (p_full_set) else $error("full flag not set"); // RULE8

    property p_rx_load;
        ce_i && ev_byte |=> rx_data_ff == $past(nxt_shift);
    endproperty
    a_rx_load: assert property (p_rx_load) else $error("byte not loaded"); // RULE10

    property p_ack_drive;
        st_ff == ISR_ACK && cnt_ff == 4'h1 |-> sda_oe_o == !ack_ctl_ff.snd;
    endproperty
    a_ack_drive: assert property (p_ack_drive) else $error("wrong ack level"); // RULE3

    property p_halt;
        ce_i && !sar_ff.fmt && !start_w && !stop_w && st_ff == ISR_ACK && cnt_ff == 4'h1
            && scl_rise && ack_ctl_ff.chk && sda_s |=> st_ff == ISR_IDLE && !sda_oe_o;
    endproperty
    a_halt: assert property (p_halt) else $error("nack did not halt"); // RULE2

    property p_ignore;
        ce_i && !sar_ff.fmt && !start_w && !stop_w && st_ff == ISR_ACK && cnt_ff == 4'h1
            && scl_rise && !ack_ctl_ff.chk |=> st_ff == ISR_ACK ##1 st_ff != ISR_IDLE;
    endproperty
    a_ignore: assert property (p_ignore) else $error("ack not ignored"); // RULE1

    property p_aas_keep;
        ce_i && aas_ff && !aas_arm_ff && !ev_match |=> aas_ff;
    endproperty
    a_aas_keep: assert property (p_aas_keep) else $error("match flag lost"); // RULE7

    property p_rd_clr;
        rd_w && hit_rx && !ev_byte |=> !rx_full_flag_ff;
    endproperty
    a_rd_clr: assert property (p_rd_clr) else $error("full not cleared"); // RULE9

    property p_bc_zero;
        ce_i && ev_ackend |=> mode_ff.bc == 3'h0 ##1 st_ff != ISR_ACK;
    endproperty
    a_bc_zero: assert property (p_bc_zero) else $error("count not zero"); // RULE12

    property p_match;
        ce_i && ev_match |=> aas_ff && st_ff == ISR_ACK && $past(nxt_shift[7:1]) == sar_ff.addr;
    endproperty
    a_match: assert property (p_match) else $error("address match lost"); // RULE6
endmodule : isr_top

// *** tb/isr_master.sv ***
// behavioural two-wire bus master driving the slave receive path
`timescale 1ns/10ps
module isr_master
(
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    // clock phase length in system cycles, the bench changes it at will
    int hp = 5;

    // bus idles released, pulled high
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic wait_hp;
        repeat (hp) @(posedge clk_i);
    endtask : wait_hp

    // also serves as repeated start, since scl is low between frames
    task automatic start_cond;
        sda_o <= 1'b1;
        wait_hp;
        scl_o <= 1'b1;
        wait_hp;
        sda_o <= 1'b0;
        wait_hp;
        scl_o <= 1'b0;
        wait_hp;
    endtask : start_cond

    task automatic stop_cond;
        sda_o <= 1'b0;
        wait_hp;
        scl_o <= 1'b1;
        wait_hp;
        sda_o <= 1'b1;
        wait_hp;
    endtask : stop_cond

    // data only moves while scl is low, so no false start or stop
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            sda_o <= b[i];
            wait_hp;
            scl_o <= 1'b1;
            wait_hp;
            scl_o <= 1'b0;
            wait_hp;
        end
        sda_o <= 1'b1;
        wait_hp;
        scl_o <= 1'b1;
        wait_hp;
        ack = sda_i;
        scl_o <= 1'b0;
        wait_hp;
    endtask : send_byte
endmodule : isr_master

// *** tb/isr_top_test.sv ***
// self-checking bench for the two-wire slave receive path
`timescale 1ns/10ps
`include "isr_cfg.svh"
module isr_top_test;
    import isr_pkg::*;
    logic clk_i, rst_i, ce, cyc, stb, we, ack, irq, sda_oe, sda_do, m_scl, m_sda, a;
    logic [17:0] adr;
    logic [3:0] sel;
    isr_word_t dat_w, dat_r;
    logic [7:0] rv, own, b;
    wire sda_bus;
    int miscompares, checks, cycles, seed;

    // open-drain wire with pull-up
    assign sda_bus = m_sda & ~(sda_oe & ~sda_do);

    isr_top isr_top_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack),
        .scl_i(m_scl), .sda_i(sda_bus), .sda_o(sda_do), .sda_oe_o(sda_oe), .irq_o(irq));
    isr_master isr_master_inst (.clk_i(clk_i), .sda_i(sda_bus), .scl_o(m_scl), .sda_o(m_sda));

    // ****************************************
    // clock, timeout and verdict
    // ****************************************
    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // ceiling well above the roughly 2000 cycles the tests need
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            miscompares++;
            complete_run;
        end
    end

    task automatic complete_run;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : complete_run

    // ****************************************
    // bus cycles and comparisons
    // ****************************************
    task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] wd,
        output logic [7:0] rd);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        dat_w <= {24'h00_0000, wd};
        // no local limit: a hung slave is caught by the cycle ceiling
        do
        begin
            @(posedge clk_i);
        end
        while (ack !== 1'b1);
        rd = dat_r[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus

    task automatic wr(input logic [15:0] idx, input logic [7:0] wd);
        logic [7:0] d;
        bus(1'b1, idx, wd, d);
    endtask : wr

    task automatic rd(input logic [15:0] idx, output logic [7:0] d);
        bus(1'b0, idx, 8'h00, d);
    endtask : rd

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // bus level in the ack slot: the sent value on a hit, released otherwise
    function automatic logic [7:0] exp_ack(input logic snd, input logic hit);
        return {7'h00, hit ? snd : 1'b1};
    endfunction : exp_ack

    // an lsb-first receiver fed by an msb-first sender sees the bits mirrored
    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        for (int i = 0; i < 8; i++)
            r[i] = v[7 - i];
        return r;
    endfunction : rev8

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        {cyc, stb, we, adr, sel, dat_w} = '0;
        ce = 1'b1;
        sel = 4'h1;
        rst_i = 1'b1;
        seed = 23;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`ISR_IDX_RX, rv);
        chk("rx reset", `ISR_RX_RST, rv);
        wr(`ISR_IDX_RX, 8'h00);
        rd(`ISR_IDX_RX, rv);
        chk("rx write", `ISR_RX_RST, rv);
        rd(16'hf079, rv);
        chk("unmapped", 8'h00, rv);
        own = 8'($random(seed)) & 8'h7f;
        wr(`ISR_IDX_SAR, {own[6:0], 1'b0});
        rd(`ISR_IDX_SAR, rv);
        chk("own addr", {own[6:0], 1'b0}, rv);
        wr(`ISR_IDX_IMK, 8'h0f);
        $display("test registers done");
        // matched address, then three random bytes acked with 0
        isr_master_inst.start_cond;
        isr_master_inst.send_byte({own[6:0], 1'b0}, a);
        chk("addr ack", exp_ack(1'b0, 1'b1), {7'h00, a});
        wr(`ISR_IDX_FLAG, 8'h00);
        rd(`ISR_IDX_FLAG, rv);
        chk("match kept", 8'h01, {7'h00, rv[1]});
        chk("irq on", 8'h01, {7'h00, irq});
        wr(`ISR_IDX_FLAG, 8'h00);
        rd(`ISR_IDX_FLAG, rv);
        chk("match clr", 8'h00, {7'h00, rv[1]});
        // frozen block must miss a whole byte: no ack, nothing loaded
        @(posedge clk_i);
        ce <= 1'b0;
        b = 8'($random(seed));
        isr_master_inst.send_byte(b, a);
        @(posedge clk_i);
        ce <= 1'b1;
        chk("frozen ack", 8'h01, {7'h00, a});
        rd(`ISR_IDX_FLAG, rv);
        chk("frozen full", 8'h00, {7'h00, rv[5]});
        for (int i = 0; i < 3; i++)
        begin
            // a nonzero count of eight bits must still fall back to 000
            if (i == 2)
                wr(16'hf078, 8'h07);
            b = 8'($random(seed));
            isr_master_inst.send_byte(b, a);
            chk("data ack", exp_ack(1'b0, 1'b1), {7'h00, a});
            rd(16'hf078, rv);
            chk("bit count", 8'h00, {5'h00, rv[2:0]});
            rd(`ISR_IDX_FLAG, rv);
            chk("full set", 8'h01, {7'h00, rv[5]});
            if (i == 0)
                wr(`ISR_IDX_FLAG, 8'h00);
            rd(`ISR_IDX_RX, rv);
            chk("rx data", b, rv);
            rd(`ISR_IDX_FLAG, rv);
            chk("full clr", 8'h00, {7'h00, rv[5]});
        end
        isr_master_inst.stop_cond;
        rd(`ISR_IDX_IST, rv);
        chk("int status", 8'h07, rv);
        wr(`ISR_IDX_IMK, 8'h00);
        chk("irq masked", 8'h00, {7'h00, irq});
        wr(`ISR_IDX_IST, 8'h0f);
        rd(`ISR_IDX_IST, rv);
        chk("int clr", 8'h00, rv);
        wr(`ISR_IDX_IMK, 8'h0f);
        $display("test receive done");
        // sending 1 with the check off: slow master, transfer goes on
        isr_master_inst.hp = 9;
        wr(`ISR_IDX_ACK, 8'h01);
        isr_master_inst.start_cond;
        isr_master_inst.send_byte({own[6:0], 1'b0}, a);
        chk("nack sent", exp_ack(1'b1, 1'b1), {7'h00, a});
        b = 8'($random(seed));
        isr_master_inst.send_byte(b, a);
        isr_master_inst.stop_cond;
        rd(`ISR_IDX_RX, rv);
        chk("no check", b, rv);
        $display("test ack ignored done");
        // check on: the refused ack halts the transfer
        isr_master_inst.hp = 4;
        wr(`ISR_IDX_ACK, 8'h05);
        rd(`ISR_IDX_ACK, rv);
        chk("ack ctl", 8'h05, rv);
        wr(`ISR_IDX_IST, 8'h0f);
        isr_master_inst.start_cond;
        isr_master_inst.send_byte({own[6:0], 1'b0}, a);
        rd(`ISR_IDX_IST, rv);
        chk("halt int", 8'h01, {7'h00, rv[3]});
        isr_master_inst.send_byte(~b, a);
        rd(`ISR_IDX_FLAG, rv);
        chk("halt full", 8'h00, {7'h00, rv[5]});
        // clocked format, lsb first: no address, no ack, bits land mirrored
        wr(16'hf078, 8'h80);
        wr(`ISR_IDX_SAR, {own[6:0], 1'b1});
        b = 8'($random(seed));
        isr_master_inst.send_byte(b, a);
        chk("clocked ack", 8'h01, {7'h00, a});
        rd(`ISR_IDX_RX, rv);
        chk("clocked rx", rev8(b), rv);
        wr(16'hf078, 8'h00);
        wr(`ISR_IDX_SAR, {own[6:0], 1'b0});
        isr_master_inst.stop_cond;
        $display("test halt done");
        // foreign address: no ack, no match flag
        wr(`ISR_IDX_ACK, 8'h00);
        rd(`ISR_IDX_FLAG, rv);
        wr(`ISR_IDX_FLAG, 8'h00);
        isr_master_inst.start_cond;
        isr_master_inst.send_byte({own[6:0] ^ 7'h01, 1'b0}, a);
        chk("foreign ack", exp_ack(1'b0, 1'b0), {7'h00, a});
        rd(`ISR_IDX_FLAG, rv);
        chk("foreign flag", 8'h00, {7'h00, rv[1]});
        isr_master_inst.stop_cond;
        $display("test foreign done");
        complete_run;
    end
endmodule : isr_top_test
